/* ext_int.sv */
// External interrupt pin block: Wishbone registers, detection, interrupt.
// Assumes a classic Wishbone master on clk_i and a pin source outside.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module ext_int (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Pin side
  input  wire logic        pin_i,
  output logic             pullup_en_o,
  // Power mode
  input  wire logic        stop_i,
  output logic             wake_o,
  // Interrupt
  output logic             irq_o,
  output logic             int_req_o
);
`include "ext_int_params.svh"

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    ext_int_pkg::bus_state_t bus;
    logic [31:0]             rdata;
    ext_int_pkg::ctrl_t      ctrl;
    logic                    event_flag;
    logic                    pe_prev;
    logic [`EV_WIDTH-1:0]    istat;
    logic [`EV_WIDTH-1:0]    imask;
  } top_state_t;

  top_state_t           state_r;
  top_state_t           state_nxt;
  ext_int_pkg::wb_req_t req;
  ext_int_pkg::detect_t det;
  logic                 access;
  logic                 wr_sc;
  logic                 wr_istat;
  logic                 wr_imask;
  logic                 ack_bit;
  logic                 set_evt;
  logic                 enable_rise;
  logic [7:0]           sc_view;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                 sel: sel_i, dat: dat_i};

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  pin_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pin_i),
    .ctrl_i (state_r.ctrl),
    .det_o  (det)
  );

  wake_path u_wake (
    .pin_i  (pin_i),
    .stop_i (stop_i),
    .ctrl_i (state_r.ctrl),
    .wake_o (wake_o)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign access   = req.cyc && req.stb && state_r.bus == ext_int_pkg::BUS_IDLE;
  assign wr_sc    = access && req.we && req.sel[0] &&
                    req.adr == `EXT_INT_SC_OFS;
  assign wr_istat = access && req.we && req.sel[0] &&
                    req.adr == `EXT_INT_ISTAT_OFS;
  assign wr_imask = access && req.we && req.sel[0] &&
                    req.adr == `EXT_INT_IMASK_OFS;
  assign ack_bit  = wr_sc && req.dat[`SC_EVENT_ACK_BIT];

  // Enable going high counts as an event
  assign enable_rise = state_r.ctrl.pin_enable && !state_r.pe_prev;
  assign set_evt     = det.edge_seen || det.level_active || enable_rise;

  // Register view: bit 7 and ack read zero
  always_comb begin
    sc_view                        = 8'h00;
    sc_view[`SC_PULL_DISABLE_BIT]  = state_r.ctrl.pull_disable;
    sc_view[`SC_EDGE_POLARITY_BIT] = state_r.ctrl.edge_polarity;
    sc_view[`SC_PIN_ENABLE_BIT]    = state_r.ctrl.pin_enable;
    sc_view[`SC_EVENT_FLAG_BIT]    = state_r.event_flag;
    sc_view[`SC_INT_ENABLE_BIT]    = state_r.ctrl.int_enable;
    sc_view[`SC_DETECT_MODE_BIT]   = state_r.ctrl.detect_mode;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt         = state_r;
    state_nxt.pe_prev = state_r.ctrl.pin_enable;

    unique case (state_r.bus)
      ext_int_pkg::BUS_IDLE: begin
        if (req.cyc && req.stb) begin
          state_nxt.bus   = ext_int_pkg::BUS_ACK;
          state_nxt.rdata = 32'h0000_0000;
          if (!req.we) begin
            unique case (req.adr)
              `EXT_INT_SC_OFS:    state_nxt.rdata = {24'h00_0000, sc_view};
              `EXT_INT_ISTAT_OFS: state_nxt.rdata = {31'h0, state_r.istat};
              `EXT_INT_IMASK_OFS: state_nxt.rdata = {31'h0, state_r.imask};
              default:            state_nxt.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      ext_int_pkg::BUS_ACK: begin
        state_nxt.bus = ext_int_pkg::BUS_IDLE;
      end
    endcase

    if (wr_sc) begin
      state_nxt.ctrl.pull_disable  = req.dat[`SC_PULL_DISABLE_BIT];
      state_nxt.ctrl.edge_polarity = req.dat[`SC_EDGE_POLARITY_BIT];
      state_nxt.ctrl.pin_enable    = req.dat[`SC_PIN_ENABLE_BIT];
      state_nxt.ctrl.int_enable    = req.dat[`SC_INT_ENABLE_BIT];
      state_nxt.ctrl.detect_mode   = req.dat[`SC_DETECT_MODE_BIT];
    end

    // Flag: ack clears, set wins; level mode holds it while asserted
    if (ack_bit) begin
      state_nxt.event_flag = 1'b0;
    end
    if (set_evt) begin
      state_nxt.event_flag = 1'b1;
    end
    if (det.level_active) begin
      state_nxt.event_flag = 1'b1;
    end

    // Sticky status, write one to clear, set wins
    if (wr_istat && req.dat[`EV_PIN_EVENT_BIT]) begin
      state_nxt.istat[`EV_PIN_EVENT_BIT] = 1'b0;
    end
    if (set_evt) begin
      state_nxt.istat[`EV_PIN_EVENT_BIT] = 1'b1;
    end
    if (wr_imask) begin
      state_nxt.imask = req.dat[`EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '{bus: ext_int_pkg::BUS_IDLE, rdata: 32'h0000_0000,
                   ctrl: '0, event_flag: 1'b0, pe_prev: 1'b0,
                   istat: `EV_RESET, imask: `EV_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign ack_o       = state_r.bus == ext_int_pkg::BUS_ACK;
  assign dat_o       = state_r.rdata;
  assign int_req_o   = state_r.ctrl.int_enable && state_r.event_flag;
  assign irq_o       = |(state_r.istat & state_r.imask);
  assign pullup_en_o = state_r.ctrl.pin_enable &&
                       !state_r.ctrl.pull_disable &&
                       !state_r.ctrl.edge_polarity;

endmodule // ext_int

`default_nettype wire

/* ext_int_params.svh */
// Constants for the external interrupt pin block: offsets, fields, resets.
// Assumes inclusion by bare name from any design or bench file.
`ifndef EXT_INT_PARAMS_SVH
`define EXT_INT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define EXT_INT_SC_OFS       4'h0
`define EXT_INT_ISTAT_OFS    4'h4
`define EXT_INT_IMASK_OFS    4'h8

// ----------------------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------------------
`define SC_RSVD_BIT          7
`define SC_PULL_DISABLE_BIT  6
`define SC_EDGE_POLARITY_BIT 5
`define SC_PIN_ENABLE_BIT    4
`define SC_EVENT_FLAG_BIT    3
`define SC_EVENT_ACK_BIT     2
`define SC_INT_ENABLE_BIT    1
`define SC_DETECT_MODE_BIT   0

// ----------------------------------------------------------------------------
// Event status / mask field positions
// ----------------------------------------------------------------------------
`define EV_PIN_EVENT_BIT     0
`define EV_WIDTH             1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SC_RESET             8'h00
`define EV_RESET             1'h0
`define SYNC_RESET           2'h0

`endif

/* ext_int_pkg.sv */
// Types shared by the external interrupt pin block.
// Assumes ext_int_params.svh is compiled alongside.
package ext_int_pkg;

  // --------------------------------------------------------------------------
  // Control bits as carried to the detector
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pull_disable;
    logic edge_polarity;
    logic pin_enable;
    logic int_enable;
    logic detect_mode;
  } ctrl_t;

  // --------------------------------------------------------------------------
  // Detector report
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic edge_seen;
    logic level_active;
    logic pin_level;
  } detect_t;

  // --------------------------------------------------------------------------
  // Wishbone slave request and answer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Bus slave phase
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

/* ext_int_sva.sv */
// Port assertions for ext_int.
// Assumes bind to ext_int; shadows control writes.
`timescale 1ns/10ps
`default_nettype none
module ext_int_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        pin_i,
  input wire logic        pullup_en_o,
  input wire logic        stop_i,
  input wire logic        wake_o,
  input wire logic        int_req_o
);
  logic [7:0] sc_r;
  logic       rq, pe, edg, on;
  assign rq  = cyc_i && stb_i;
  assign pe  = sc_r[4];
  assign edg = sc_r[5];
  assign on  = pe && sc_r[1] && !rq;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      sc_r <= 8'h00;
    else if (rq && !ack_o && we_i && sel_i[0] && adr_i == 4'h0)
      sc_r <= dat_i[7:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet; on && pin_i != edg; endsequence
  sequence s_held; (on && pin_i == edg)[*5]; endsequence
  property p_ack; rq && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_rd;
    ack_o && !we_i |-> (dat_o & 32'hFFFFFF84) == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("zero bits");
  property p_pull; pullup_en_o == (pe && !sc_r[6] && !edg); endproperty
  a_pull: assert property (p_pull) else $error("pull");
  property p_wake; wake_o == (stop_i && pe && pin_i == edg); endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_ie; !sc_r[1] |-> !int_req_o; endproperty
  a_ie: assert property (p_ie) else $error("irq off");
  property p_edge; s_quiet ##1 s_held |-> int_req_o; endproperty
  a_edge: assert property (p_edge) else $error("edge");
  property p_lvl;
    (pe && sc_r[1:0] == 2'b11 && pin_i == edg)[*6] |-> int_req_o;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level");
endmodule // ext_int_sva
bind ext_int ext_int_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .dat_o, .pin_i, .pullup_en_o, .stop_i,
  .wake_o,
  .int_req_o);
`default_nettype wire

/* pin_src.sv */
// Pin source model for ext_int: drives the pin or releases it.
// Assumes pull_i follows the block's pullup enable.
`timescale 1ns/10ps
`default_nettype none
module pin_src (
  input  wire logic clk_i,
  input  wire logic drive_i,
  input  wire logic lvl_i,
  input  wire logic pull_i,
  output logic      pin_o
);
  logic last_r;
  // Remember the last driven level; a floating pin shows its inverse, or 1 while pull_i is high
  always_ff @(posedge clk_i) begin
    if (drive_i) begin
      last_r <= lvl_i;
    end
  end
  assign pin_o = drive_i ? lvl_i : (pull_i ? 1'b1 : ~last_r);
endmodule // pin_src
`default_nettype wire

/* pin_sync.sv */
// Two-stage synchroniser with edge and level detection for the pin.
// Assumes pin is asynchronous to clk_i; output valid from reset onward.
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Pin and control
  input  wire logic              pin_i,
  input  wire ext_int_pkg::ctrl_t ctrl_i,
  // Report
  output ext_int_pkg::detect_t   det_o
);
`include "ext_int_params.svh"

  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;
  logic        asserted;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt      = state_r;
    state_nxt.sync = {state_r.sync[0], pin_i};
    state_nxt.prev = state_r.sync[1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Asserted level follows polarity: 1 high, 0 low
  assign asserted = state_r.sync[1] == ctrl_i.edge_polarity;

  always_comb begin
    det_o.pin_level    = state_r.sync[1];
    // Edge: previous sample deasserted, current asserted
    det_o.edge_seen    = ctrl_i.pin_enable && asserted &&
                         (state_r.prev != ctrl_i.edge_polarity);
    det_o.level_active = ctrl_i.pin_enable && ctrl_i.detect_mode &&
                         asserted;
  end

endmodule // pin_sync

`default_nettype wire

/* tb.sv */
// Self-checking bench for ext_int over classic Wishbone.
// Assumes ext_int, pin_src and ext_int_sva are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, stop_i, drv, lvl;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rdat;
  logic        ack_o, pin_i, pullup_en_o, wake_o, irq_o, int_req_o;
  int          n_fail = 0, checks_done = 0;
  ext_int u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .ack_o, .dat_o, .pin_i, .pullup_en_o, .stop_i, .wake_o,
    .irq_o, .int_req_o);
  pin_src u_src (.clk_i, .drive_i(drv), .lvl_i(lvl), .pull_i(pullup_en_o),
    .pin_o(pin_i));
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Hold request until ack is seen at a rising edge, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rdat, {24'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {clk_i, cyc_i, stb_i, we_i, stop_i, adr_i, dat_i} = '0;
    {rst_i, drv, lvl, sel_i} = 7'h7F;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, 8'h00);
    rd(4'hC, 8'h00);
    wb(1'b1, 4'h0, 8'h10);
    rd(4'h0, 8'h18);
    chk(32'(pullup_en_o), 32'h1);
    wb(1'b1, 4'h0, 8'h14);
    rd(4'h0, 8'h10);
    wb(1'b1, 4'h0, 8'h12);
    chk(32'(int_req_o), 32'h0);
    lvl <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(4'h0, 8'h1A);
    chk(32'(int_req_o), 32'h1);
    wb(1'b1, 4'h0, 8'h16);
    rd(4'h0, 8'h12);
    wb(1'b1, 4'h0, 8'h17);
    rd(4'h0, 8'h1B);
    drv <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b1, 4'h0, 8'h17);
    rd(4'h0, 8'h13);
    {drv, lvl} <= 2'b11;
    wb(1'b1, 4'h0, 8'h36);
    chk(32'(pullup_en_o), 32'h0);
    lvl <= 1'b0;
    repeat (6) @(posedge clk_i);
    lvl <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(4'h0, 8'h3A);
    wb(1'b1, 4'h0, 8'h46);
    lvl <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(4'h0, 8'h42);
    wb(1'b1, 4'h0, 8'h50);
    rd(4'h0, 8'h58);
    chk(32'(pullup_en_o), 32'h0);
    rd(4'h4, 8'h01);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, 4'h8, 8'h01);
    chk(32'(irq_o), 32'h1);
    wb(1'b1, 4'h4, 8'h01);
    rd(4'h4, 8'h00);
    chk(32'(irq_o), 32'h0);
    stop_i <= 1'b1;
    @(posedge clk_i);
    chk(32'(wake_o), 32'h1);
    rst_i  <= 1'b1;
    stop_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({irq_o, int_req_o, pullup_en_o, wake_o}), 32'h0);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    report_and_stop;
  end
endmodule // tb
`default_nettype wire

/* wake_path.sv */
// Asynchronous wake request for stop mode, built from gates only.
// Assumes stop_i is high while the system clock is halted.
`timescale 1ns/10ps
`default_nettype none

module wake_path (
  // Pin and mode
  input  wire logic              pin_i,
  input  wire logic              stop_i,
  input  wire ext_int_pkg::ctrl_t ctrl_i,
  // Wake request
  output logic                   wake_o
);

  // Raw pin at asserted level, no clock involved
  always_comb begin
    wake_o = stop_i && ctrl_i.pin_enable &&
             (pin_i == ctrl_i.edge_polarity);
  end

endmodule // wake_path

`default_nettype wire
